// ---- src/edcm_device.sv ----
`timescale 1ns/1ps
`default_nettype none
module edcm_device (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link to controller
  edcm_if.dev dev
);
  import edcm_pkg::*;

  // ****************************************
  // Code tables
  // ****************************************
  // Column of the check matrix for data bit i, odd weight of at least three
  function automatic logic [7:0] col(input int i);
    logic [6:0] low;
    low = (i == 0) ? 7'h07 : {1'b1, i[5:0]};
    return {~^low, low};
  endfunction

  function automatic logic [7:0] gen_cb(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h0;
    for (int i = 0; i < EDCM_DW; i++) begin
      if (d[i]) begin
        c = c ^ col(i);
      end
    end
    return c;
  endfunction

  function automatic edcm_mode_type mode_of(input logic [1:0] ds, input logic cor);
    edcm_mode_type m;
    case (ds)
      EDCM_DS_NORMAL: m = cor ? EDCM_CORRECT : EDCM_DETECT;
      EDCM_DS_GEN: m = cor ? EDCM_DIAG_GEN : EDCM_GENERATE;
      EDCM_DS_DIAGDET: m = cor ? EDCM_DIAG_CORRECT : EDCM_DIAG_DETECT;
      EDCM_DS_SPECIAL: m = cor ? EDCM_INIT : EDCM_PASS;
      default: m = EDCM_DETECT;
    endcase
    return m;
  endfunction

  function automatic logic corrects(input edcm_mode_type m);
    return (m == EDCM_CORRECT) || (m == EDCM_DIAG_CORRECT);
  endfunction

  function automatic logic flags_forced(input edcm_mode_type m);
    return (m == EDCM_PASS) || (m == EDCM_INIT) || (m == EDCM_GENERATE) || (m == EDCM_DIAG_GEN);
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [63:0] diag;
    logic [63:0] din;
    logic [7:0] cbin;
    logic [1:0] cfg;
    logic [1:0] ds;
    logic cor;
    logic pend;
    logic [63:0] dout;
    logic [7:0] synd;
    logic sf_n;
    logic mf_n;
    logic vld;
  } edcm_dev_state_type;

  edcm_dev_state_type s_q;
  edcm_dev_state_type s_d;

  // ****************************************
  // Working signals
  // ****************************************
  logic [63:0] flip;
  logic [7:0] gen;
  logic [7:0] syn;
  logic single;
  logic multi;
  edcm_mode_type mode_up;
  edcm_mode_type mode_lo;
  logic [31:0] lo_out;
  logic [31:0] up_out;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.vld = 1'b0;
    s_d.pend = 1'b0;
    flip = 64'h0;
    // Mode selection, internal control uses the latch fields
    if (s_q.cfg == EDCM_CFG_INTERNAL) begin
      mode_up = mode_of(s_q.diag[EDCM_DL_UP_DS +: 2], s_q.diag[EDCM_DL_UP_COR]);
      mode_lo = mode_of(s_q.diag[EDCM_DL_LO_DS +: 2], s_q.diag[EDCM_DL_LO_COR]);
    end else begin
      mode_up = mode_of(s_q.ds, s_q.cor);
      mode_lo = mode_up;
    end
    gen = gen_cb(s_q.din);
    // Upper-half diagnostic detect and correct modes compare against the latch check bits
    if (mode_up == EDCM_DIAG_DETECT || mode_up == EDCM_DIAG_CORRECT) begin
      syn = gen ^ s_q.diag[EDCM_DL_CHK +: EDCM_CW];
    end else begin
      syn = gen ^ s_q.cbin;
    end
    // Both halves decode the one upper syndrome
    for (int i = 0; i < EDCM_DW; i++) begin
      flip[i] = (syn == col(i));
    end
    single = (syn != 8'h0);
    multi = single && (~^syn || ($countones(syn) > 1 && flip == 64'h0));
    // Check-bit errors leave data untouched, flip stays zero
    lo_out = corrects(mode_lo) ? (s_q.din[31:0] ^ flip[31:0]) : s_q.din[31:0];
    up_out = corrects(mode_up) ? (s_q.din[63:32] ^ flip[63:32]) : s_q.din[63:32];
    if (mode_lo == EDCM_INIT) begin
      lo_out = 32'h0;
    end
    if (mode_up == EDCM_INIT) begin
      up_out = 32'h0;
    end
    if (s_q.pend) begin
      s_d.vld = 1'b1;
      s_d.dout = {up_out, lo_out};
      case (mode_up)
        EDCM_GENERATE: s_d.synd = gen;
        EDCM_DIAG_GEN: s_d.synd = s_q.diag[EDCM_DL_CHK +: EDCM_CW];
        EDCM_PASS: s_d.synd = s_q.cbin;
        EDCM_INIT: s_d.synd = gen_cb(64'h0);
        default: s_d.synd = syn;
      endcase
      if (!dev.synd_drive_en) begin
        s_d.synd = 8'h0;
      end
      if (flags_forced(mode_up)) begin
        s_d.sf_n = 1'b1;
        s_d.mf_n = 1'b1;
      end else begin
        s_d.sf_n = ~single;
        s_d.mf_n = ~multi;
      end
    end
    // Input latch and controls captured together
    if (dev.in_strobe) begin
      s_d.din = dev.data_in;
      s_d.cbin = dev.checkbit_in;
      s_d.cfg = dev.config_select;
      s_d.ds = dev.diag_select;
      s_d.cor = dev.correct_en;
      s_d.pend = 1'b1;
    end
    if (dev.diag_load) begin
      s_d.diag = dev.data_in;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.diag <= EDCM_DL_RESET;
      s_q.sf_n <= 1'b1;
      s_q.mf_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dev.data_out = s_q.dout;
  assign dev.syndrome_checkbit_out = s_q.synd;
  assign dev.single_fault_flag_n = s_q.sf_n;
  assign dev.multi_fault_flag_n = s_q.mf_n;
  assign dev.out_valid = s_q.vld;

endmodule
`default_nettype wire

// ---- src/edcm_pkg.sv ----
package edcm_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int EDCM_DW = 64;
  localparam int EDCM_CW = 8;

  // ****************************************
  // Control encodings
  // ****************************************
  localparam logic [1:0] EDCM_CFG_INTERNAL = 2'h3;
  localparam logic [1:0] EDCM_DS_NORMAL = 2'h0;
  localparam logic [1:0] EDCM_DS_GEN = 2'h1;
  localparam logic [1:0] EDCM_DS_DIAGDET = 2'h2;
  localparam logic [1:0] EDCM_DS_SPECIAL = 2'h3;

  typedef enum {
    EDCM_DETECT, EDCM_CORRECT, EDCM_GENERATE, EDCM_DIAG_GEN,
    EDCM_DIAG_DETECT, EDCM_DIAG_CORRECT, EDCM_PASS, EDCM_INIT
  } edcm_mode_type;

  // ****************************************
  // Diagnostic latch field positions
  // ****************************************
  localparam int EDCM_DL_CHK = 0;
  localparam int EDCM_DL_LO_CFG = 8;
  localparam int EDCM_DL_LO_DS = 10;
  localparam int EDCM_DL_LO_COR = 12;
  localparam int EDCM_DL_UP_CFG = 40;
  localparam int EDCM_DL_UP_DS = 42;
  localparam int EDCM_DL_UP_COR = 44;
  localparam logic [63:0] EDCM_DL_RESET = 64'h0;

  // ****************************************
  // Controller register map (byte addresses)
  // ****************************************
  localparam logic [7:0] EDCM_REG_CTRL = 8'h00;
  localparam logic [7:0] EDCM_REG_DLO = 8'h04;
  localparam logic [7:0] EDCM_REG_DHI = 8'h08;
  localparam logic [7:0] EDCM_REG_CHK = 8'h0c;
  localparam logic [7:0] EDCM_REG_CMD = 8'h10;
  localparam logic [7:0] EDCM_REG_STAT = 8'h14;
  localparam logic [7:0] EDCM_REG_RLO = 8'h18;
  localparam logic [7:0] EDCM_REG_RHI = 8'h1c;
  localparam int EDCM_CMD_GO = 0;
  localparam int EDCM_CMD_DLOAD = 1;
  localparam logic [4:0] EDCM_CTRL_RESET = 5'h0;

endpackage

// ---- src/edcm_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface edcm_if;
  import edcm_pkg::*;
  logic [EDCM_DW-1:0] data_in;
  logic [EDCM_CW-1:0] checkbit_in;
  logic in_strobe;
  logic diag_load;
  logic [1:0] config_select;
  logic [1:0] diag_select;
  logic correct_en;
  logic synd_drive_en;
  logic [EDCM_DW-1:0] data_out;
  logic [EDCM_CW-1:0] syndrome_checkbit_out;
  logic single_fault_flag_n;
  logic multi_fault_flag_n;
  logic out_valid;

  modport dev (
    input data_in, checkbit_in, in_strobe, diag_load, config_select, diag_select, correct_en, synd_drive_en,
    output data_out, syndrome_checkbit_out, single_fault_flag_n, multi_fault_flag_n, out_valid
  );
  modport ctl (
    output data_in, checkbit_in, in_strobe, diag_load, config_select, diag_select, correct_en, synd_drive_en,
    input data_out, syndrome_checkbit_out, single_fault_flag_n, multi_fault_flag_n, out_valid
  );
endinterface
`default_nettype wire

// ---- src/edcm_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module edcm_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Software port
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // Link to device
  edcm_if.ctl ctl
);
  import edcm_pkg::*;

  typedef struct packed {
    logic [4:0] ctrl;
    logic [63:0] wdat;
    logic [7:0] chk;
    logic [63:0] res;
    logic [7:0] syn;
    logic sf_n;
    logic mf_n;
    logic done;
    logic busy;
    logic strobe;
    logic dload;
    logic [31:0] rdata;
  } edcm_ctl_state_type;

  edcm_ctl_state_type s_q;
  edcm_ctl_state_type s_d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    s_d.dload = 1'b0;
    s_d.rdata = 32'h0;
    if (sw_rd) begin
      case (sw_addr)
        EDCM_REG_CTRL: s_d.rdata = {27'h0, s_q.ctrl};
        EDCM_REG_DLO: s_d.rdata = s_q.wdat[31:0];
        EDCM_REG_DHI: s_d.rdata = s_q.wdat[63:32];
        EDCM_REG_CHK: s_d.rdata = {24'h0, s_q.chk};
        EDCM_REG_STAT: s_d.rdata = {16'h0, s_q.syn, 4'h0, s_q.mf_n, s_q.sf_n, s_q.busy, s_q.done};
        EDCM_REG_RLO: s_d.rdata = s_q.res[31:0];
        EDCM_REG_RHI: s_d.rdata = s_q.res[63:32];
        default: s_d.rdata = 32'h0;
      endcase
      if (sw_addr == EDCM_REG_STAT) begin
        s_d.done = 1'b0;
      end
    end
    if (sw_wr) begin
      case (sw_addr)
        EDCM_REG_CTRL: s_d.ctrl = sw_wdata[4:0];
        EDCM_REG_DLO: s_d.wdat[31:0] = sw_wdata;
        EDCM_REG_DHI: s_d.wdat[63:32] = sw_wdata;
        EDCM_REG_CHK: s_d.chk = sw_wdata[7:0];
        EDCM_REG_CMD: begin
          // A go command is ignored until the previous result is in
          if (!s_q.busy && sw_wdata[EDCM_CMD_GO]) begin
            s_d.strobe = 1'b1;
            s_d.busy = 1'b1;
          end
          s_d.dload = sw_wdata[EDCM_CMD_DLOAD];
        end
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    // Result capture; the done set wins over a status read
    if (ctl.out_valid && s_q.busy) begin
      s_d.res = ctl.data_out;
      s_d.syn = ctl.syndrome_checkbit_out;
      s_d.sf_n = ctl.single_fault_flag_n;
      s_d.mf_n = ctl.multi_fault_flag_n;
      s_d.done = 1'b1;
      s_d.busy = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.ctrl <= EDCM_CTRL_RESET;
      s_q.sf_n <= 1'b1;
      s_q.mf_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign sw_rdata = s_q.rdata;
  assign ctl.data_in = s_q.wdat;
  assign ctl.checkbit_in = s_q.chk;
  assign ctl.in_strobe = s_q.strobe;
  assign ctl.diag_load = s_q.dload;
  assign ctl.config_select = s_q.ctrl[1:0];
  assign ctl.diag_select = s_q.ctrl[3:2];
  assign ctl.correct_en = s_q.ctrl[4];
  assign ctl.synd_drive_en = 1'b1;

endmodule
`default_nettype wire

// ---- tb/edcm_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module edcm_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Controller side
  input wire logic [edcm_pkg::EDCM_DW-1:0] data_in,
  input wire logic [edcm_pkg::EDCM_CW-1:0] checkbit_in,
  input wire logic in_strobe,
  input wire logic diag_load,
  input wire logic [1:0] config_select,
  input wire logic [1:0] diag_select,
  input wire logic correct_en,
  input wire logic synd_drive_en,
  // Device side
  input wire logic [edcm_pkg::EDCM_DW-1:0] data_out,
  input wire logic [edcm_pkg::EDCM_CW-1:0] syndrome_checkbit_out,
  input wire logic single_fault_flag_n,
  input wire logic multi_fault_flag_n,
  input wire logic out_valid
);
  import edcm_pkg::*;
  logic [EDCM_CW-1:0] dl_chk_q;
  // ****************************************
  // Copy of the latched check bits
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dl_chk_q <= '0;
    end else if (diag_load) begin
      dl_chk_q <= data_in[EDCM_CW-1:0];
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_ext(logic [1:0] ds, logic ce);
    in_strobe && config_select != EDCM_CFG_INTERNAL && diag_select == ds && correct_en == ce;
  endsequence
  sequence s_forced;
    in_strobe && config_select != EDCM_CFG_INTERNAL && diag_select[0];
  endsequence
  sequence s_answer;
    ##2 out_valid;
  endsequence
  AST_VALID_LAT: assert property (in_strobe |-> s_answer)
    else $error("answer not two cycles after strobe");
  AST_VALID_CAUSE: assert property (out_valid |-> $past(in_strobe, 2))
    else $error("answer without strobe");
  AST_SYND_EN: assert property (out_valid |-> synd_drive_en)
    else $error("syndrome drivers off");
  AST_FORCED_FLAGS: assert property (s_forced |-> ##2 single_fault_flag_n && multi_fault_flag_n)
    else $error("fault flags not forced high");
  AST_INIT_DATA: assert property (s_ext(2'h3, 1'b1) |-> ##2 data_out == '0 && syndrome_checkbit_out == '0)
    else $error("initialize output not zero");
  AST_PASS_DATA: assert property (s_ext(2'h3, 1'b0) |->
    ##2 data_out == $past(data_in, 2) && syndrome_checkbit_out == $past(checkbit_in, 2))
    else $error("pass output differs");
  AST_DETECT_DATA: assert property (s_ext(EDCM_DS_NORMAL, 1'b0) |-> ##2 data_out == $past(data_in, 2))
    else $error("detect altered data");
  AST_MULT_SINGLE: assert property (out_valid && !multi_fault_flag_n |-> !single_fault_flag_n)
    else $error("multi flag without single flag");
  AST_NO_ERR: assert property (out_valid && syndrome_checkbit_out == '0 |-> single_fault_flag_n)
    else $error("flag with zero syndrome");
  // A latch load on the strobe edge already feeds the answer
  AST_DIAG_GEN: assert property (s_ext(EDCM_DS_GEN, 1'b1) |-> ##2 syndrome_checkbit_out == $past(dl_chk_q, 1))
    else $error("diag generate check bits wrong");
endmodule
`default_nettype wire

// ---- tb/edc_operating_modes_64bit_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module edc_operating_modes_64bit_test;
  import edcm_pkg::*;
  logic sys_clk, sys_rst, sw_wr, sw_rd;
  logic [7:0] sw_addr, c;
  logic [31:0] sw_wdata, sw_rdata, v;
  logic [63:0] d, lat;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  edcm_if lnk();
  edcm_device edcm_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .dev(lnk));
  edcm_ctrl edcm_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ctl(lnk));
  edcm_asserts edcm_asserts_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .data_in(lnk.data_in),
    .checkbit_in(lnk.checkbit_in), .in_strobe(lnk.in_strobe), .diag_load(lnk.diag_load),
    .config_select(lnk.config_select), .diag_select(lnk.diag_select), .correct_en(lnk.correct_en),
    .synd_drive_en(lnk.synd_drive_en), .data_out(lnk.data_out), .syndrome_checkbit_out(lnk.syndrome_checkbit_out),
    .single_fault_flag_n(lnk.single_fault_flag_n), .multi_fault_flag_n(lnk.multi_fault_flag_n),
    .out_valid(lnk.out_valid));
  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] cbits(input logic [63:0] x);
    logic [7:0] r;
    logic [6:0] l;
    r = '0;
    for (int i = 0; i < 64; i++) begin
      l = (i == 0) ? 7'h07 : {1'b1, 6'(i)};
      if (x[i]) r ^= {~^l, l};
    end
    return r;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= w;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1;
    r = sw_rdata;
  endtask
  task automatic ld(input logic [63:0] w);
    wr(EDCM_REG_DLO, w[31:0]);
    wr(EDCM_REG_DHI, w[63:32]);
    wr(EDCM_REG_CMD, 32'h2);
  endtask
  // One transfer: mode, data, check bits, then expected data, syndrome, {multi_n, single_n}
  task automatic op(input logic [4:0] m, input logic [63:0] di, input logic [7:0] ci,
    input logic [63:0] ed, input logic [7:0] es, input logic [1:0] ef, input logic cd);
    logic [31:0] st, lo, hi;
    st = '0;
    wr(EDCM_REG_CTRL, {27'h0, m});
    wr(EDCM_REG_DLO, di[31:0]);
    wr(EDCM_REG_DHI, di[63:32]);
    wr(EDCM_REG_CHK, {24'h0, ci});
    wr(EDCM_REG_CMD, 32'h1);
    for (int k = 0; k < 20 && st[0] !== 1'b1; k++) rd(EDCM_REG_STAT, st);
    chk(64'(st), 64'({16'h0, es, 4'h0, ef, 2'b01}));
    rd(EDCM_REG_RLO, lo);
    rd(EDCM_REG_RHI, hi);
    if (cd) chk({hi, lo}, ed);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    sw_addr = '0;
    sw_wdata = '0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    d = 64'h0123_4567_89ab_cdef;
    c = cbits(d);
    rd(8'h20, v);
    chk(64'(v), 64'h0);
    rd(EDCM_REG_CTRL, v);
    chk(64'(v), 64'h0);
    op(5'h1c, d, c, 64'h0, 8'h00, 2'h3, 1'b1);
    op(5'h04, d, 8'h00, d, c, 2'h3, 1'b0);
    op(5'h00, d, c, d, 8'h00, 2'h3, 1'b1);
    op(5'h10, d ^ 64'h20, c, d, cbits(64'h20), 2'h2, 1'b1);
    op(5'h00, d ^ 64'h60, c, d ^ 64'h60, cbits(64'h60), 2'h0, 1'b1);
    op(5'h10, d, c ^ 8'h08, d, 8'h08, 2'h2, 1'b1);
    op(5'h0c, d ^ 64'h20, 8'h5a, d ^ 64'h20, 8'h5a, 2'h3, 1'b1);
    op(5'h1c, d, c, 64'h0, 8'h00, 2'h3, 1'b1);
    lat = {32'h0000_0c00, 24'h00000c, c};
    ld(lat);
    op(5'h14, 64'h0, 8'h00, 64'h0, c, 2'h3, 1'b0);
    op(5'h08, d, 8'h00, d, 8'h00, 2'h3, 1'b1);
    op(5'h18, d ^ 64'h20, 8'h00, d, cbits(64'h20), 2'h2, 1'b1);
    op(5'h03, d ^ 64'h20, 8'h5a, d ^ 64'h20, 8'h5a, 2'h3, 1'b1);
    // Lower half corrects, upper half only detects
    lat = {32'h0000_0000, 24'h000010, c};
    ld(lat);
    op(5'h03, d ^ 64'h20, c, d, cbits(64'h20), 2'h2, 1'b1);
    op(5'h03, d ^ 64'h20_0000_0000, c, d ^ 64'h20_0000_0000, cbits(64'h20_0000_0000), 2'h2, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
